// ==== hdl/apmap_pkg.sv ====
/*
 * apmap_pkg: offsets, reset values and fixed identification values of the
 * access-port register map. Assumes word-aligned 32-bit APB4 accesses.
 */
package apmap_pkg;
    localparam int          ADDR_W          = 13;
    localparam int          DATA_W          = 32;
    localparam int          DA_WORDS        = 256;
    // view select bit: 0x0000 first view, 0x1000 second view
    localparam int          VIEW_BIT        = 12;
    localparam logic [11:0] OFS_DA_LAST     = 12'h3fc;
    localparam logic [11:0] OFS_CTRL        = 12'hd00;
    localparam logic [11:0] OFS_TADDR       = 12'hd04;
    localparam logic [11:0] OFS_DRW         = 12'hd0c;
    localparam logic [11:0] OFS_BD0         = 12'hd10;
    localparam logic [11:0] OFS_BD1         = 12'hd14;
    localparam logic [11:0] OFS_BD2         = 12'hd18;
    localparam logic [11:0] OFS_BD3         = 12'hd1c;
    localparam logic [11:0] OFS_RESP        = 12'hd24;
    localparam logic [11:0] OFS_CFG         = 12'hdf4;
    localparam logic [11:0] OFS_BASE        = 12'hdf8;
    localparam logic [11:0] OFS_IDENT       = 12'hdfc;
    localparam logic [11:0] OFS_ITSTAT      = 12'hefc;
    localparam logic [11:0] OFS_INTEGRATION_MODE_CONTROL      = 12'hf00;
    localparam logic [11:0] OFS_CLAIM_TAG_SET    = 12'hfa0;
    localparam logic [11:0] OFS_CLAIM_TAG_CLEAR    = 12'hfa4;
    localparam logic [11:0] OFS_AUTH        = 12'hfb8;
    localparam logic [11:0] OFS_DEVICE_ARCHITECTURE     = 12'hfbc;
    localparam logic [11:0] OFS_DEVICE_TYPE_CODE     = 12'hfcc;
    localparam logic [11:0] OFS_PID4        = 12'hfd0;
    localparam logic [11:0] OFS_PID5        = 12'hfd4;
    localparam logic [11:0] OFS_PID6        = 12'hfd8;
    localparam logic [11:0] OFS_PID7        = 12'hfdc;
    localparam logic [11:0] OFS_PID0        = 12'hfe0;
    localparam logic [11:0] OFS_PID1        = 12'hfe4;
    localparam logic [11:0] OFS_PID2        = 12'hfe8;
    localparam logic [11:0] OFS_PID3        = 12'hfec;
    localparam logic [11:0] OFS_CID0        = 12'hff0;
    localparam logic [11:0] OFS_CID1        = 12'hff4;
    localparam logic [11:0] OFS_CID2        = 12'hff8;
    localparam logic [11:0] OFS_CID3        = 12'hffc;
    localparam logic [31:0] RST_RESP        = 32'h0000_0000;
    localparam logic [31:0] RST_ITSTAT      = 32'h0000_0000;
    localparam logic [31:0] RST_INTEGRATION_MODE_CONTROL      = 32'h0000_0000;
    localparam logic [31:0] RST_CLAIM_TAG_SET    = 32'h0000_0003;
    localparam logic [31:0] RST_CLAIM_TAG_CLEAR    = 32'h0000_0000;
    localparam logic [31:0] VAL_CFG         = 32'h0001_01a0;
    localparam logic [31:0] VAL_AUTH        = 32'h0000_0000;
    localparam logic [31:0] VAL_DEVICE_TYPE_CODE     = 32'h0000_0000;
    localparam logic [31:0] VAL_ZERO        = 32'h0000_0000;
    localparam logic [31:0] VAL_CID0        = 32'h0000_000d;
    localparam logic [31:0] VAL_CID1        = 32'h0000_0090;
    localparam logic [31:0] VAL_CID2        = 32'h0000_0005;
    localparam logic [31:0] VAL_CID3        = 32'h0000_00b1;
    localparam logic [31:0] MASK_1KB        = 32'hffff_fc00;
    localparam logic [1:0]  CLAIM_BITS      = 2'h3;
    // arbitrary neutral identity values
    localparam logic [31:0] DEF_IDENT       = 32'h0000_0001;
    localparam logic [31:0] DEF_DEVICE_ARCHITECTURE     = 32'h0000_0002;
    localparam logic [31:0] DEF_PID0        = 32'h0000_0010;
    localparam logic [31:0] DEF_PID1        = 32'h0000_0020;
    localparam logic [31:0] DEF_PID2        = 32'h0000_0030;
    localparam logic [31:0] DEF_PID4        = 32'h0000_0000;

    typedef enum logic [1:0] {
        APMAP_IDLE = 2'b01,
        APMAP_MEM  = 2'b10
    } apmap_state_t;
endpackage

// ==== hdl/apmap_regs.sv ====
/*
 * apmap_regs: APB4 slave register map of a debug memory-access port,
 * two views of 4KB each, with a direct-access window into target memory.
 * Assumes the debug-port master and the memory-side port share ref_clk;
 * the memory side answers each request with mem_done.
 */
// Overview of operation
// (R01) The 8KB space holds two register views, one at 0x0000 and one at 0x1000.
// (R02) Only one view serves a port; the second exists but serves no twin port.
// (R03) Each read-write register has one copy per view, written independently.
// (R04) Each read-only register is shared, so both views read the same value.
// (R05) Offsets not assigned to a listed register are reserved.
// (R06) Registers with dashed reset values leave reset with unspecified contents.
// (R07) A window of 256 read-write words spans offsets 0x0000 to 0x03fc.
// (R08) The claim tag set register at 0x0fa0 reads 3 after reset.
// (R09) The configuration register at 0x0df4 reads the fixed value 0x000101a0.
// (R10) The transfer response register at 0x0d24 resets to zero in both views.
// (R11) A window word maps to memory at the masked transfer address plus its offset.
// (R12) The access control word steers accesses issued into the memory system.
// (R13) Reserved offsets read zero, ignore writes and never signal an error.
`timescale 1ns/1ps
module apmap_regs #(
    parameter logic [31:0] BASE_ADDR = 32'h0000_0000
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // apb4 slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [12:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic [2:0]  pprot,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // memory-side request
    output logic             mem_req,
    output logic             mem_write,
    output logic [31:0]      mem_addr,
    output logic [31:0]      mem_wdata,
    output logic [31:0]      mem_ctrl,
    input  wire logic        mem_done,
    input  wire logic [31:0] mem_rdata
);
    localparam int NV = 2;

    apmap_pkg::apmap_state_t state_reg;
    logic [31:0] ctrl_reg    [NV];
    logic [31:0] taddr_reg   [NV];
    logic [31:0] drw_reg     [NV];
    logic [31:0] bd_reg      [NV][4];
    logic [31:0] resp_reg    [NV];
    logic [31:0] itstat_reg  [NV];
    logic [31:0] integration_mode_control_reg  [NV];
    logic [1:0]  claim_reg   [NV];
    logic [31:0] rdata_reg;
    logic        done_reg;

    wire logic        view   = paddr[apmap_pkg::VIEW_BIT];
    wire logic [11:0] ofs    = {paddr[11:2], 2'b00};
    wire logic        setup  = psel && !penable;
    wire logic        acc    = psel && penable;
    wire logic        is_da  = (ofs <= apmap_pkg::OFS_DA_LAST); // [R07]
    wire logic        wr_hit = acc && pwrite && pready;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic wr_at(input logic [11:0] o, input logic v);
        return wr_hit && (ofs == o) && (view == v);
    endfunction

    // window words go out to memory; pready held low until after mem_done
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= apmap_pkg::APMAP_IDLE;
        end else begin
            case (state_reg)
                apmap_pkg::APMAP_IDLE: begin
                    if (setup && is_da) begin
                        state_reg <= apmap_pkg::APMAP_MEM;
                    end
                end
                apmap_pkg::APMAP_MEM: begin
                    if (mem_done) begin
                        state_reg <= apmap_pkg::APMAP_IDLE;
                    end
                end
                default: state_reg <= apmap_pkg::APMAP_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mem_write <= 1'b0;
            mem_addr  <= 32'h0000_0000;
            mem_wdata <= 32'h0000_0000;
            mem_ctrl  <= 32'h0000_0000;
        end else if (setup && is_da && state_reg == apmap_pkg::APMAP_IDLE) begin
            mem_write <= pwrite;
            mem_addr  <= (taddr_reg[view] & apmap_pkg::MASK_1KB)
                         + {22'h0, paddr[9:0]}; // [R11]
            mem_wdata <= pwdata;
            mem_ctrl  <= ctrl_reg[view]; // [R12]
        end
    end

    // one wait state after mem_done so prdata already holds the memory word
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= mem_req && mem_done; // [R11]
        end
    end

    assign mem_req = (state_reg == apmap_pkg::APMAP_MEM);
    assign pready  = !(acc && is_da) || done_reg;
    assign pslverr = 1'b0; // [R13]

    // one copy per view of every read-write register
    always_ff @(posedge ref_clk) begin
        for (int v = 0; v < NV; v++) begin
            if (wr_at(apmap_pkg::OFS_CTRL, v[0])) begin
                ctrl_reg[v] <= merge(ctrl_reg[v], pwdata, pstrb); // [R03] [R06]
            end
            if (wr_at(apmap_pkg::OFS_TADDR, v[0])) begin
                taddr_reg[v] <= merge(taddr_reg[v], pwdata, pstrb); // [R03]
            end
            if (wr_at(apmap_pkg::OFS_DRW, v[0])) begin
                drw_reg[v] <= merge(drw_reg[v], pwdata, pstrb);
            end
            for (int b = 0; b < 4; b++) begin
                if (wr_at(apmap_pkg::OFS_BD0 + 12'(4 * b), v[0])) begin
                    bd_reg[v][b] <= merge(bd_reg[v][b], pwdata, pstrb);
                end
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int v = 0; v < NV; v++) begin
                resp_reg[v]   <= apmap_pkg::RST_RESP; // [R10]
                itstat_reg[v] <= apmap_pkg::RST_ITSTAT;
                integration_mode_control_reg[v] <= apmap_pkg::RST_INTEGRATION_MODE_CONTROL;
                claim_reg[v]  <= apmap_pkg::RST_CLAIM_TAG_CLEAR[1:0];
            end
        end else begin
            for (int v = 0; v < NV; v++) begin
                if (wr_at(apmap_pkg::OFS_RESP, v[0])) begin
                    resp_reg[v] <= merge(resp_reg[v], pwdata, pstrb); // [R03]
                end
                if (wr_at(apmap_pkg::OFS_ITSTAT, v[0])) begin
                    itstat_reg[v] <= merge(itstat_reg[v], pwdata, pstrb);
                end
                if (wr_at(apmap_pkg::OFS_INTEGRATION_MODE_CONTROL, v[0])) begin
                    integration_mode_control_reg[v] <= merge(integration_mode_control_reg[v], pwdata, pstrb);
                end
                if (wr_at(apmap_pkg::OFS_CLAIM_TAG_SET, v[0]) && pstrb[0]) begin
                    claim_reg[v] <= claim_reg[v]
                                    | (pwdata[1:0] & apmap_pkg::CLAIM_BITS);
                end else if (wr_at(apmap_pkg::OFS_CLAIM_TAG_CLEAR, v[0]) && pstrb[0]) begin
                    claim_reg[v] <= claim_reg[v] & ~pwdata[1:0];
                end
            end
        end
    end

    // read decode; read-only values shared, view bit ignored
    function automatic logic [31:0] rd_mux(input logic [11:0] o, input logic v);
        logic [31:0] r;
        r = 32'h0000_0000; // [R05] [R13]
        case (o)
            apmap_pkg::OFS_CTRL:     r = ctrl_reg[v];
            apmap_pkg::OFS_TADDR:    r = taddr_reg[v];
            apmap_pkg::OFS_DRW:      r = drw_reg[v];
            apmap_pkg::OFS_BD0:      r = bd_reg[v][0];
            apmap_pkg::OFS_BD1:      r = bd_reg[v][1];
            apmap_pkg::OFS_BD2:      r = bd_reg[v][2];
            apmap_pkg::OFS_BD3:      r = bd_reg[v][3];
            apmap_pkg::OFS_RESP:     r = resp_reg[v];
            apmap_pkg::OFS_CFG:      r = apmap_pkg::VAL_CFG; // [R09] [R04]
            apmap_pkg::OFS_BASE:     r = BASE_ADDR;
            apmap_pkg::OFS_IDENT:    r = apmap_pkg::DEF_IDENT;
            apmap_pkg::OFS_ITSTAT:   r = itstat_reg[v];
            apmap_pkg::OFS_INTEGRATION_MODE_CONTROL:   r = integration_mode_control_reg[v];
            apmap_pkg::OFS_CLAIM_TAG_SET: r = {30'h0, apmap_pkg::CLAIM_BITS}; // [R08]
            apmap_pkg::OFS_CLAIM_TAG_CLEAR: r = {30'h0, claim_reg[v]};
            apmap_pkg::OFS_AUTH:     r = apmap_pkg::VAL_AUTH;
            apmap_pkg::OFS_DEVICE_ARCHITECTURE:  r = apmap_pkg::DEF_DEVICE_ARCHITECTURE;
            apmap_pkg::OFS_DEVICE_TYPE_CODE:  r = apmap_pkg::VAL_DEVICE_TYPE_CODE;
            apmap_pkg::OFS_PID4:     r = apmap_pkg::DEF_PID4;
            apmap_pkg::OFS_PID5:     r = apmap_pkg::VAL_ZERO;
            apmap_pkg::OFS_PID6:     r = apmap_pkg::VAL_ZERO;
            apmap_pkg::OFS_PID7:     r = apmap_pkg::VAL_ZERO;
            apmap_pkg::OFS_PID0:     r = apmap_pkg::DEF_PID0;
            apmap_pkg::OFS_PID1:     r = apmap_pkg::DEF_PID1;
            apmap_pkg::OFS_PID2:     r = apmap_pkg::DEF_PID2;
            apmap_pkg::OFS_PID3:     r = apmap_pkg::VAL_ZERO;
            apmap_pkg::OFS_CID0:     r = apmap_pkg::VAL_CID0;
            apmap_pkg::OFS_CID1:     r = apmap_pkg::VAL_CID1;
            apmap_pkg::OFS_CID2:     r = apmap_pkg::VAL_CID2;
            apmap_pkg::OFS_CID3:     r = apmap_pkg::VAL_CID3;
            default:                 r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // data captured at setup; window data when memory answers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (mem_req && mem_done) begin
            rdata_reg <= mem_write ? 32'h0000_0000 : mem_rdata; // [R11]
        end else if (setup && !pwrite) begin
            rdata_reg <= rd_mux(ofs, view); // [R01] [R02]
        end
    end

    assign prdata = rdata_reg;

    // protection attributes carried but not decoded
    logic [31:0] unused_prot;
    assign unused_prot = {29'h0, pprot};

    AST_NO_ERR: assert property (@(posedge ref_clk) disable iff (rst)
        psel |-> !pslverr) else $error("slave error raised"); // [R13]
    AST_CFG_RD: assert property (@(posedge ref_clk) disable iff (rst)
        setup && !pwrite && ofs == apmap_pkg::OFS_CFG
        |=> prdata == apmap_pkg::VAL_CFG) else $error("config value wrong"); // [R09]
    AST_CLAIM_RD: assert property (@(posedge ref_clk) disable iff (rst)
        setup && !pwrite && ofs == apmap_pkg::OFS_CLAIM_TAG_SET
        |=> prdata == 32'h0000_0003) else $error("claim set value wrong"); // [R08]
    AST_RSV_RD: assert property (@(posedge ref_clk) disable iff (rst)
        setup && !pwrite && ofs == 12'hd08 |=> prdata == 32'h0000_0000)
        else $error("reserved read not zero"); // [R05]
    AST_VIEW_SEP: assert property (@(posedge ref_clk) disable iff (rst)
        wr_at(apmap_pkg::OFS_RESP, 1'b0) |=> $stable(resp_reg[1]))
        else $error("second view touched"); // [R03]
    AST_RESP_RST: assert property (@(posedge ref_clk)
        rst |=> resp_reg[0] == 32'h0 && resp_reg[1] == 32'h0)
        else $error("response not reset"); // [R10]
    AST_DA_ADDR: assert property (@(posedge ref_clk) disable iff (rst)
        setup && is_da && state_reg == apmap_pkg::APMAP_IDLE
        |=> mem_req && mem_addr[9:0] == $past(paddr[9:0]))
        else $error("window address wrong"); // [R07] [R11]
    AST_RO_SHARED: assert property (@(posedge ref_clk) disable iff (rst)
        setup && !pwrite && ofs == apmap_pkg::OFS_CID3
        |=> prdata == apmap_pkg::VAL_CID3) else $error("shared read wrong"); // [R04]
    AST_CTRL_OUT: assert property (@(posedge ref_clk) disable iff (rst)
        setup && is_da && state_reg == apmap_pkg::APMAP_IDLE
        |=> mem_ctrl == $past(ctrl_reg[view])) else $error("ctrl not passed"); // [R12]
    AST_NO_ERR_V1: assert property (@(posedge ref_clk) disable iff (rst)
        psel && view |-> !pslverr) else $error("view 1 error"); // [R02]
    AST_RSV_WR: assert property (@(posedge ref_clk) disable iff (rst)
        acc && pwrite && ofs == 12'hd08 |-> pready) else $error("reserved stall"); // [R13]
    AST_WIN_DATA: assert property (@(posedge ref_clk) disable iff (rst)
        mem_req && mem_done && !mem_write |=> pready && prdata == $past(mem_rdata))
        else $error("window read data not ready with pready"); // [R11]
    AST_WIN_WAIT: assert property (@(posedge ref_clk) disable iff (rst)
        acc && is_da && mem_req |-> !pready) else $error("window ready too early"); // [R11]

    COV_WIN:  cover property (@(posedge ref_clk) mem_req && mem_done);
    COV_V1:   cover property (@(posedge ref_clk) wr_hit && view);
    COV_CLR:  cover property (@(posedge ref_clk) wr_at(apmap_pkg::OFS_CLAIM_TAG_CLEAR, 1'b0));
    COV_WRD:  cover property (@(posedge ref_clk) mem_req && mem_done && !mem_write);
    COV_DAV1: cover property (@(posedge ref_clk) setup && is_da && view);
endmodule // apmap_regs

// ==== verif/access_port_register_map_tb.sv ====
/*
 * access_port_register_map_tb: self-checking bench for apmap_regs.
 * Assumes zero-wait register accesses and window answers via apmap_mem_model.
 */
`timescale 1ns/1ps
module access_port_register_map_tb;
    logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [12:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic [2:0]  pprot;
    logic        mem_req, mem_write, mem_done, cap_write;
    logic [31:0] mem_addr, mem_wdata, mem_ctrl, mem_rdata, cap_addr, cap_wdata;
    int          num_errors;
    int          compares;
    localparam logic [11:0] RV_OFS [12] = '{12'hd24, 12'hdf4, 12'hefc, 12'hf00, 12'hfa0,
        12'hfa4, 12'hfb8, 12'hfcc, 12'hff0, 12'hff4, 12'hff8, 12'hffc};
    localparam logic [31:0] RV_VAL [12] = '{32'h0, 32'h0001_01a0, 32'h0, 32'h0, 32'h3,
        32'h0, 32'h0, 32'h0, 32'h0000_000d, 32'h0000_0090, 32'h0000_0005, 32'h0000_00b1};
    localparam logic [11:0] RW_OFS [8] = '{12'hd00, 12'hd04, 12'hd0c, 12'hd10, 12'hd14,
        12'hd18, 12'hd1c, 12'hd24};
    localparam logic [11:0] RSV_OFS [5] = '{12'h400, 12'hd08, 12'hd20, 12'he00, 12'hfa8};

    apmap_regs dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .mem_req(mem_req),
        .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ctrl(mem_ctrl), .mem_done(mem_done), .mem_rdata(mem_rdata));
    apmap_mem_model partner (.ref_clk(ref_clk), .rst(rst), .mem_req(mem_req),
        .mem_write(mem_write), .mem_addr(mem_addr), .mem_done(mem_done),
        .mem_rdata(mem_rdata));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // last completed memory request
    always @(posedge ref_clk) begin
        if (mem_req && mem_done) begin
            cap_addr  <= mem_addr;
            cap_wdata <= mem_wdata;
            cap_write <= mem_write;
        end
    end

    function automatic logic [31:0] mem_value(input logic [31:0] a);
        return a ^ 32'h3c5a_0000;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [12:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        psel = 1'b1;
        pwrite = wr;
        paddr = a;
        pwdata = d;
        @(negedge ref_clk);
        penable = 1'b1;
        n = 0;
        // let the combinational ready settle after penable rises
        #1;
        while (pready !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        check({31'h0, pready}, 32'h1, "ready");
        check({31'h0, pslverr}, 32'h0, "error response");
        q = prdata;
        @(negedge ref_clk);
        psel = 1'b0;
        penable = 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic finish_test;
        $display("counts: %0d compares, %0d mismatches", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #(25ns * 20000);
        num_errors++;
        $display("BAD t=%0t run did not complete", $time);
        finish_test();
    end

    initial begin
        logic [31:0] q;
        logic [31:0] t;
        logic [31:0] ta [2];
        logic [31:0] cw [2];
        logic [11:0] o;
        logic        v;
        {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 3'b000, 13'h0, 32'h0};
        pstrb = 4'hf;
        pprot = 3'h0;
        num_errors = 0;
        compares = 0;
        q = $urandom(39882);
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        for (int i = 0; i < 24; i++) begin
            apb(1'b0, {1'(i % 2), RV_OFS[i / 2]}, 32'h0, q);
            check(q, RV_VAL[i / 2], "reset value");
        end
        $display("test reset_values done");
        for (int i = 0; i < 8; i++) begin
            t = $urandom();
            apb(1'b1, {1'b0, RW_OFS[i]}, t, q);
            apb(1'b1, {1'b1, RW_OFS[i]}, ~t, q);
            apb(1'b0, {1'b0, RW_OFS[i]}, 32'h0, q);
            check(q, t, "first view copy");
            apb(1'b0, {1'b1, RW_OFS[i]}, 32'h0, q);
            check(q, ~t, "second view copy");
        end
        apb(1'b1, 13'h0df4, $urandom(), q);
        apb(1'b0, 13'h1df4, 32'h0, q);
        check(q, 32'h0001_01a0, "read-only after write");
        $display("test views done");
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        for (int i = 0; i < 2; i++) begin
            apb(1'b0, {1'(i), 12'hd24}, 32'h0, q);
            check(q, 32'h0, "response after second reset");
        end
        apb(1'b1, 13'h0fa0, 32'h1, q);
        apb(1'b0, 13'h0fa4, 32'h0, q);
        check(q, 32'h1, "claim tag set");
        apb(1'b0, 13'h1fa4, 32'h0, q);
        check(q, 32'h0, "claim tag other view");
        apb(1'b1, 13'h0fa4, 32'h1, q);
        apb(1'b0, 13'h0fa4, 32'h0, q);
        check(q, 32'h0, "claim tag clear");
        $display("test reset_and_claim done");
        for (int i = 0; i < 10; i++) begin
            apb(1'b1, {1'(i % 2), RSV_OFS[i / 2]}, $urandom(), q);
            apb(1'b0, {1'(i % 2), RSV_OFS[i / 2]}, 32'h0, q);
            check(q, 32'h0, "reserved offset");
        end
        $display("test reserved done");
        ta[0] = $urandom();
        ta[1] = $urandom();
        apb(1'b1, 13'h0d04, ta[0], q);
        apb(1'b1, 13'h1d04, ta[1], q);
        cw[0] = $urandom();
        cw[1] = $urandom();
        apb(1'b1, 13'h0d00, cw[0], q);
        apb(1'b1, 13'h1d00, cw[1], q);
        for (int i = 0; i < 16; i++) begin
            o = (i < 4) ? 12'({8'h0, 8'h1, 8'h2, 8'hff} >> (8 * (3 - i))) : 12'($urandom());
            o = {o[7:0], 2'b00} & 12'h3fc;
            v = 1'(i % 2);
            t = $urandom();
            apb(1'b1, {v, o}, t, q);
            check({31'h0, cap_write}, 32'h1, "window write kind");
            check(cap_addr, (ta[v] & 32'hffff_fc00) + 32'(o), "window address");
            check(cap_wdata, t, "window write data");
            check(mem_ctrl, cw[v], "window control");
            apb(1'b0, {v, o}, 32'h0, q);
            check({31'h0, cap_write}, 32'h0, "window read kind");
            check(q, mem_value((ta[v] & 32'hffff_fc00) + 32'(o)), "window read");
        end
        $display("test window done");
        finish_test();
    end
endmodule // access_port_register_map_tb

// ==== verif/apmap_mem_model.sv ====
/*
 * apmap_mem_model: target memory behind the direct-access window.
 * Assumes mem_req stays high until mem_done; answers after 1 to 4 cycles.
 */
`timescale 1ns/1ps
module apmap_mem_model (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // request from the port
    input  wire logic        mem_req,
    input  wire logic        mem_write,
    input  wire logic [31:0] mem_addr,
    // answer
    output logic             mem_done,
    output logic [31:0]      mem_rdata
);
    logic [1:0] wait_reg;
    logic [1:0] delay_reg;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mem_done  <= 1'b0;
            mem_rdata <= 32'h0000_0000;
            wait_reg  <= 2'h0;
            delay_reg <= 2'h0;
        end else if (mem_req && !mem_done && wait_reg == delay_reg) begin
            // read data is a function of the target address
            mem_done  <= 1'b1;
            mem_rdata <= mem_write ? ~mem_rdata : (mem_addr ^ 32'h3c5a_0000);
            wait_reg  <= 2'h0;
            delay_reg <= 2'($urandom_range(3));
        end else begin
            // data line not held outside the answer cycle
            mem_done  <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_reg  <= (mem_req && !mem_done) ? wait_reg + 2'h1 : 2'h0;
        end
    end
endmodule // apmap_mem_model
